// File: packet_channel_access_sequencer.sv
// Functional notes
// - abandon request if rate status below requested rate
// - attempt start loads initial preamble power
// - attempt start loads retry counter with retry limit
// - random frame from rate's sub-channel group; random even/odd
// - random preamble signature from the rate's set
// - random collision signature from the collision set
// - random offset within plus/minus maximum per preamble
// - rate recheck before each preamble; abandon and report
// - access preamble, then collision preamble at same power
// - no indication: next group frame, new collision signature
// - retry adds normal step, alternative while timer runs
// - decrement retry counter; below zero fails, else redraw offset
// - negative indication abandons and reports failure
// - negative indication starts alternative-step timer
// - positive indication with wrong collision signature fails
// - message preamble after delay, on match and free channel
// - message preamble power is preamble power plus offset
// - message part right after message preamble, no gap
// - message power follows each power control command
// - command 00,01,10,11 map to step -2,-1,1,2
module packet_channel_access_sequencer
  import common_packet_channel_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // MAC side
  input wire logic i_access_request,
  input wire logic [1:0] i_requested_rate,
  input wire logic i_message_end,
  output logic o_busy,
  output logic o_access_success,
  output logic o_access_failure,
  // downlink indicators, same clock
  input wire logic [1:0] i_rate_status,
  input wire logic i_indicator_valid,
  input wire logic i_ack_positive,
  input wire logic i_ack_negative,
  input wire logic i_collision_valid,
  input wire logic [3:0] i_collision_sig,
  input wire logic i_channel_assignment_valid,
  input wire logic [3:0] i_channel_assignment,
  input wire logic [15:0] i_channel_status_broadcast,
  input wire logic i_power_control_valid,
  input wire logic [1:0] i_power_control_command,
  // uplink transmitter
  output logic o_access_preamble_tx,
  output logic o_collision_detect_preamble_tx,
  output logic o_message_preamble_tx,
  output logic o_message_start,
  output logic [2:0] o_access_frame,
  output logic o_sub_frame_odd,
  output logic [3:0] o_access_preamble_sig,
  output logic [3:0] o_collision_detect_preamble_sig,
  output logic signed [7:0] o_tx_offset,
  output logic [7:0] o_preamble_power,
  output logic [7:0] o_message_power
);

  // ==========================================================
  // helpers
  function automatic logic [4:0] pick_bit(input logic [15:0] m,
                                          input logic [3:0] s);
    logic [4:0] r;
    logic [3:0] k;
    r = 5'h10;
    // walk down: nearest set bit at or after s wins
    for (int i = 15; i >= 0; i--) begin
      k = s + 4'(i);
      if (m[k]) begin
        r = {1'b0, k};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] sat_add(input logic [7:0] p,
                                         input logic signed [9:0] d);
    logic signed [10:0] s;
    s = $signed({3'b000, p}) + 11'(d);
    if (s < 0) begin
      return 8'h00;
    end else if (s > 11'sd255) begin
      return 8'hFF;
    end
    return s[7:0];
  endfunction

  // ==========================================================
  // register bus
  logic [31:0] cfg [CFG_WORDS];
  logic [31:0] rd_words [ALL_WORDS];
  logic [31:0] wmask;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic wr_go;
  logic wr_hit;
  logic rd_go;
  logic rd_hit;

  assign wr_go = i_awvalid & i_wvalid & ~o_bvalid;
  assign o_awready = wr_go;
  assign o_wready = wr_go;
  assign wr_idx = i_awaddr[5:2];
  assign wr_hit = (i_awaddr[7:6] == 2'b00) && (wr_idx < 4'(CFG_WORDS));
  assign rd_go = i_arvalid & ~o_rvalid;
  assign o_arready = rd_go;
  assign rd_idx = i_araddr[5:2];
  assign rd_hit = (i_araddr[7:6] == 2'b00) && (rd_idx < 4'(ALL_WORDS));
  assign wmask = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
                  {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};

  for (genvar g = 0; g < CFG_WORDS; g++) begin : g_cfg
    logic [31:0] merged;
    assign merged = ((cfg[g] & ~wmask) | (i_wdata & wmask)) & CFG_MASK[g];
    assign rd_words[g] = cfg[g];
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        cfg[g] <= CFG_RST[g];
      end else if (wr_go && wr_hit && wr_idx == 4'(g)) begin
        cfg[g] <= merged;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rresp <= RESP_OKAY;
      o_rdata <= 32'h0000_0000;
    end else if (rd_go) begin
      o_rvalid <= 1'b1;
      o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      o_rdata <= rd_hit ? rd_words[rd_idx] : 32'h0000_0000;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // configuration fields
  logic sub_en;
  logic [7:0] init_power;
  logic [7:0] retry_limit;
  logic [7:0] step_normal;
  logic [7:0] step_alt;
  logic [6:0] offset_max;
  logic [7:0] msg_offset;
  logic [15:0] msg_delay;
  logic [15:0] neg_time;
  logic [7:0] subch_mask;
  logic [15:0] sig_mask;
  logic [15:0] col_sig_mask;
  logic [31:0] sig_word;

  assign sub_en = cfg[REG_CTRL[5:2]][CTRL_SUB_EN];
  assign init_power = cfg[REG_INIT_POWER[5:2]][7:0];
  assign retry_limit = cfg[REG_RETRY_LIMIT[5:2]][7:0];
  assign step_normal = cfg[REG_RAMP_STEP[5:2]][7:0];
  assign step_alt = cfg[REG_RAMP_STEP[5:2]][RAMP_ALT_LSB +: 8];
  assign offset_max = cfg[REG_OFFSET_MAX[5:2]][6:0];
  assign msg_offset = cfg[REG_MSG_OFFSET[5:2]][7:0];
  assign msg_delay = cfg[REG_MSG_DELAY[5:2]][15:0];
  assign neg_time = cfg[REG_NEG_TIME[5:2]][15:0];
  assign col_sig_mask = cfg[REG_COL_SIG_MASK[5:2]][15:0];

  // ==========================================================
  // sequencer state
  seq_state_t state, next_state;
  logic [1:0] rate, next_rate;
  logic [7:0] power, next_power;
  logic [7:0] msg_power, next_msg_power;
  logic signed [8:0] retry, next_retry;
  logic [2:0] frame, next_frame;
  logic odd, next_odd;
  logic [3:0] pre_sig, next_pre_sig;
  logic [3:0] col_sig, next_col_sig;
  logic signed [7:0] offset, next_offset;
  logic [15:0] since_tx, next_since_tx;
  logic [7:0] pre_cnt, next_pre_cnt;
  logic pre_tx, col_tx, msg_pre_tx, msg_go, ok, fail, neg_start;
  logic last_ok, last_fail;
  logic [15:0] neg_timer;
  logic neg_running;
  logic [15:0] rnd;
  logic [8:0] frame_div;
  logic [2:0] frame_idx;
  logic frame_tick;
  logic [4:0] frame_pick, sig_pick, col_pick;
  logic [3:0] frame_start;
  logic [7:0] ramp;
  logic signed [8:0] retry_dec;
  logic signed [2:0] pc_step;
  logic rate_short;
  logic listen_retry;

  common_packet_channel_lfsr u_lfsr (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .o_rand(rnd)
  );

  // access frame timing
  assign frame_tick = frame_div == 9'(ACC_FRAME_CYCLES - 1);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      frame_div <= 9'h000;
      frame_idx <= 3'h0;
    end else begin
      frame_div <= frame_tick ? 9'h000 : frame_div + 9'h001;
      frame_idx <= frame_tick ? frame_idx + 3'h1 : frame_idx;
    end
  end

  assign subch_mask = cfg[REG_SUBCH_MASK[5:2]][8 * rate +: 8];
  assign sig_word = rate[1] ? cfg[REG_SIG_MASK_23[5:2]]
                            : cfg[REG_SIG_MASK_01[5:2]];
  assign sig_mask = rate[0] ? sig_word[31:16] : sig_word[15:0];
  // retries walk on from the last frame, first pick is random
  assign frame_start = (state == ST_LISTEN) ? {1'b0, frame + 3'h1}
                                            : {1'b0, rnd[2:0]};
  assign frame_pick = pick_bit({8'h00, subch_mask}, frame_start);
  assign sig_pick = pick_bit(sig_mask, rnd[7:4]);
  assign col_pick = pick_bit(col_sig_mask, rnd[11:8]);
  assign neg_running = neg_timer != 16'h0000;
  assign ramp = neg_running ? step_alt : step_normal;
  assign retry_dec = retry - 9'sd1;
  assign rate_short = i_rate_status < rate;
  assign pc_step = i_power_control_command[1]
                 ? (i_power_control_command[0] ? STEP_UP_2 : STEP_UP_1)
                 : (i_power_control_command[0] ? STEP_DOWN_1 : STEP_DOWN_2);
  assign listen_retry = !i_ack_negative
                      && !(i_ack_positive && i_collision_valid);

  always_comb begin
    next_state = state;
    next_rate = rate;
    next_power = power;
    next_msg_power = msg_power;
    next_retry = retry;
    next_frame = frame;
    next_odd = odd;
    next_pre_sig = pre_sig;
    next_col_sig = col_sig;
    next_offset = offset;
    next_since_tx = (since_tx == 16'hFFFF) ? since_tx : since_tx + 16'h0001;
    next_pre_cnt = pre_cnt;
    pre_tx = 1'b0;
    col_tx = 1'b0;
    msg_pre_tx = 1'b0;
    msg_go = 1'b0;
    ok = 1'b0;
    fail = 1'b0;
    neg_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_access_request) begin
          next_rate = i_requested_rate;
          if (i_rate_status < i_requested_rate) begin
            fail = 1'b1;
          end else begin
            next_power = init_power;
            next_retry = $signed({1'b0, retry_limit});
            next_state = ST_PICK;
          end
        end
      end
      ST_PICK: begin
        if (frame_pick[4] || sig_pick[4] || col_pick[4]) begin
          fail = 1'b1;
        end else begin
          next_frame = frame_pick[2:0];
          next_odd = sub_en & rnd[15];
          next_pre_sig = sig_pick[3:0];
          next_col_sig = col_pick[3:0];
          next_state = ST_OFFSET;
        end
      end
      ST_OFFSET: begin
        // rejection draw keeps the offset uniform
        if ({1'b0, rnd[7:0]} <= {1'b0, offset_max, 1'b0}) begin
          next_offset = 8'({1'b0, rnd[7:0]} - {2'b00, offset_max});
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (frame_tick && (frame_idx + 3'h1) == frame) begin
          if (rate_short) begin
            fail = 1'b1;
          end else begin
            pre_tx = 1'b1;
            next_since_tx = 16'h0000;
            next_state = ST_COLLIDE;
          end
        end
      end
      ST_COLLIDE: begin
        col_tx = 1'b1;
        next_state = ST_LISTEN;
      end
      ST_LISTEN: begin
        if (i_indicator_valid) begin
          if (i_ack_negative) begin
            fail = 1'b1;
            neg_start = 1'b1;
          end else if (!listen_retry) begin
            if (i_collision_sig != col_sig) begin
              fail = 1'b1;
            end else if (i_channel_assignment_valid &&
                i_channel_status_broadcast[i_channel_assignment]) begin
              next_state = ST_MSG_WAIT;
            end else begin
              fail = 1'b1;
            end
          end else if (retry_dec < 0 || frame_pick[4] || col_pick[4]) begin
            next_retry = retry_dec;
            fail = 1'b1;
          end else begin
            next_retry = retry_dec;
            next_frame = frame_pick[2:0];
            next_odd = sub_en & rnd[15];
            next_col_sig = col_pick[3:0];
            next_power = sat_add(power, $signed({2'b00, ramp}));
            next_state = ST_OFFSET;
          end
        end
      end
      ST_MSG_WAIT: begin
        if (since_tx >= msg_delay) begin
          msg_pre_tx = 1'b1;
          next_msg_power = sat_add(power, $signed({2'b00, msg_offset}));
          next_pre_cnt = 8'h00;
          next_state = ST_MSG_PRE;
        end
      end
      ST_MSG_PRE: begin
        if (pre_cnt == 8'(MSG_PRE_CYCLES - 1)) begin
          msg_go = 1'b1;
          ok = 1'b1;
          next_state = ST_MSG;
        end else begin
          next_pre_cnt = pre_cnt + 8'h01;
        end
      end
      ST_MSG: begin
        if (i_power_control_valid) begin
          next_msg_power = sat_add(msg_power, 10'(pc_step));
        end
        if (i_message_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (fail) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      rate <= 2'b00;
      power <= 8'h00;
      msg_power <= 8'h00;
      retry <= 9'sd0;
      frame <= 3'h0;
      odd <= 1'b0;
      pre_sig <= 4'h0;
      col_sig <= 4'h0;
      offset <= 8'sd0;
      since_tx <= 16'h0000;
      pre_cnt <= 8'h00;
    end else begin
      state <= next_state;
      rate <= next_rate;
      power <= next_power;
      msg_power <= next_msg_power;
      retry <= next_retry;
      frame <= next_frame;
      odd <= next_odd;
      pre_sig <= next_pre_sig;
      col_sig <= next_col_sig;
      offset <= next_offset;
      since_tx <= next_since_tx;
      pre_cnt <= next_pre_cnt;
    end
  end

  // timer outlives the attempt so the next one ramps by the alternative step (2 at reset, normal is 1)
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      neg_timer <= 16'h0000;
    end else if (neg_start) begin
      neg_timer <= neg_time;
    end else if (neg_running) begin
      neg_timer <= neg_timer - 16'h0001;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_access_preamble_tx <= 1'b0;
      o_collision_detect_preamble_tx <= 1'b0;
      o_message_preamble_tx <= 1'b0;
      o_message_start <= 1'b0;
      o_access_success <= 1'b0;
      o_access_failure <= 1'b0;
      last_ok <= 1'b0;
      last_fail <= 1'b0;
    end else begin
      o_access_preamble_tx <= pre_tx;
      o_collision_detect_preamble_tx <= col_tx;
      o_message_preamble_tx <= msg_pre_tx;
      o_message_start <= msg_go;
      o_access_success <= ok;
      o_access_failure <= fail;
      last_ok <= ok ? 1'b1 : (fail ? 1'b0 : last_ok);
      last_fail <= fail ? 1'b1 : (ok ? 1'b0 : last_fail);
    end
  end

  assign o_busy = state != ST_IDLE;
  assign o_access_frame = frame;
  assign o_sub_frame_odd = odd;
  assign o_access_preamble_sig = pre_sig;
  assign o_collision_detect_preamble_sig = col_sig;
  assign o_tx_offset = offset;
  assign o_preamble_power = power;
  assign o_message_power = msg_power;

  assign rd_words[REG_STATUS[5:2]] = {16'h0000, state, neg_running,
                                      last_fail, last_ok, retry};
  assign rd_words[REG_POWER[5:2]] = {16'h0000, msg_power, power};

endmodule // packet_channel_access_sequencer

// File: common_packet_channel_seq_pkg.sv
package common_packet_channel_seq_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ACC_FRAME_NS = 10_000;
  localparam int unsigned ACC_FRAME_CYCLES = ACC_FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned MSG_PRE_NS = 5_000;
  localparam int unsigned MSG_PRE_CYCLES = MSG_PRE_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INIT_POWER = 8'h04;
  localparam logic [7:0] REG_RETRY_LIMIT = 8'h08;
  localparam logic [7:0] REG_RAMP_STEP = 8'h0C;
  localparam logic [7:0] REG_OFFSET_MAX = 8'h10;
  localparam logic [7:0] REG_MSG_OFFSET = 8'h14;
  localparam logic [7:0] REG_MSG_DELAY = 8'h18;
  localparam logic [7:0] REG_NEG_TIME = 8'h1C;
  localparam logic [7:0] REG_SUBCH_MASK = 8'h20;
  localparam logic [7:0] REG_SIG_MASK_01 = 8'h24;
  localparam logic [7:0] REG_SIG_MASK_23 = 8'h28;
  localparam logic [7:0] REG_COL_SIG_MASK = 8'h2C;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_POWER = 8'h34;
  localparam int unsigned CFG_WORDS = 12;
  localparam int unsigned ALL_WORDS = 14;

  // field positions
  localparam int unsigned CTRL_SUB_EN = 0;
  localparam int unsigned RAMP_ALT_LSB = 8;

  // reset values and writable bits
  localparam logic [31:0] CFG_RST [CFG_WORDS] = '{
    32'h0000_0000, 32'h0000_0010, 32'h0000_0004, 32'h0000_0201,
    32'h0000_0008, 32'h0000_0003, 32'h0000_0320, 32'h0000_0FA0,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF};
  localparam logic [31:0] CFG_MASK [CFG_WORDS] = '{
    32'h0000_0001, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_FFFF,
    32'h0000_007F, 32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF};

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // power control step codes
  localparam logic signed [2:0] STEP_DOWN_2 = -3'sd2;
  localparam logic signed [2:0] STEP_DOWN_1 = -3'sd1;
  localparam logic signed [2:0] STEP_UP_1 = 3'sd1;
  localparam logic signed [2:0] STEP_UP_2 = 3'sd2;

  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PICK = 4'b0001,
    ST_OFFSET = 4'b0010,
    ST_WAIT = 4'b0011,
    ST_COLLIDE = 4'b0100,
    ST_LISTEN = 4'b0101,
    ST_MSG_WAIT = 4'b0110,
    ST_MSG_PRE = 4'b0111,
    ST_MSG = 4'b1000
  } seq_state_t;

endpackage

// File: common_packet_channel_lfsr.sv
module common_packet_channel_lfsr
  import common_packet_channel_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  output logic [15:0] o_rand
);

  logic [15:0] state;
  logic feedback;

  // taps 16,14,13,11: maximal length, never zero
  assign feedback = state[15] ^ state[13] ^ state[12] ^ state[10];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= LFSR_SEED;
    end else begin
      state <= {state[14:0], feedback};
    end
  end

  assign o_rand = state;

endmodule // common_packet_channel_lfsr

// File: packet_channel_access_sequencer_monitor.sv
module packet_channel_access_sequencer_monitor
  import common_packet_channel_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_access_request,
  input wire logic [1:0] i_requested_rate,
  input wire logic [1:0] i_rate_status,
  input wire logic i_message_end,
  input wire logic i_indicator_valid,
  input wire logic i_ack_positive,
  input wire logic i_ack_negative,
  input wire logic i_collision_valid,
  input wire logic [3:0] i_collision_sig,
  input wire logic i_power_control_valid,
  input wire logic [1:0] i_power_control_command,
  input wire logic o_busy,
  input wire logic o_access_success,
  input wire logic o_access_failure,
  input wire logic o_access_preamble_tx,
  input wire logic o_collision_detect_preamble_tx,
  input wire logic o_message_preamble_tx,
  input wire logic o_message_start,
  input wire logic [3:0] o_collision_detect_preamble_sig,
  input wire logic signed [7:0] o_tx_offset,
  input wire logic [7:0] o_preamble_power,
  input wire logic [7:0] o_message_power
);
  // ==========================================================
  // helpers
  localparam int OFF_MAX = 8;
  logic listen;
  logic in_msg;
  wire logic [1:0] cmd = i_power_control_command;
  wire logic [7:0] tpc_delta = {{6{~cmd[1]}}, cmd[1] ? {cmd[0], ~cmd[0]} :
                                {1'b1, cmd[0]}};
  wire logic clash = i_collision_sig != o_collision_detect_preamble_sig;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      listen <= 1'b0;
      in_msg <= 1'b0;
    end else begin
      listen <= o_collision_detect_preamble_tx | (listen & ~i_indicator_valid);
      in_msg <= o_message_start | (in_msg & ~i_message_end);
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // properties
  a_rate_refuse: assert property (i_access_request && !o_busy &&
    i_requested_rate > i_rate_status |=> o_access_failure)
    else $error("rate refuse");
  a_offset_range: assert property (o_access_preamble_tx |->
    o_tx_offset <= OFF_MAX && o_tx_offset >= -OFF_MAX)
    else $error("offset range");
  a_cd_follows: assert property (o_access_preamble_tx |=>
    o_collision_detect_preamble_tx && $stable(o_preamble_power))
    else $error("no cd preamble");
  a_neg_fails: assert property (listen && i_indicator_valid &&
    i_ack_negative |=> o_access_failure)
    else $error("nack kept");
  a_clash_fails: assert property (listen && i_indicator_valid &&
    i_ack_positive && i_collision_valid && clash |=> o_access_failure)
    else $error("clash kept");
  a_msg_gap: assert property (o_message_preamble_tx |-> ##200
    o_message_start) else $error("message start gap");
  a_start_success: assert property (o_message_start ==
    o_access_success) else $error("success timing");
  a_one_outcome: assert property (!(o_access_success &&
    o_access_failure)) else $error("two outcomes");
  a_tpc_step: assert property (in_msg && i_power_control_valid |=>
    o_message_power == 8'($past(o_message_power) + $past(tpc_delta)))
    else $error("power step wrong");
  c_success: cover property (o_access_success);
  c_quiet: cover property (listen && i_indicator_valid && !i_ack_positive);
  c_tpc: cover property (in_msg && i_power_control_valid);
endmodule // packet_channel_access_sequencer_monitor

bind packet_channel_access_sequencer packet_channel_access_sequencer_monitor
  u_mon (.*);

// File: common_packet_channel_net_model.sv
module common_packet_channel_net_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cd_tx,
  input wire logic [3:0] i_cd_sig,
  input wire logic [2:0] i_mode,
  input wire logic [7:0] i_dly,
  output logic o_ind,
  output logic o_pos,
  output logic o_neg,
  output logic o_col_valid,
  output logic [3:0] o_col_sig,
  output logic o_ca_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode 0 silent, 1 negative, 2 positive match, 3 positive clash
  logic pend;
  logic tg;
  logic [7:0] cnt;
  logic [3:0] sig;
  // qualifiers toggle outside the indicator pulse: no stale values
  assign o_pos = o_ind ? i_mode[1] : tg;
  assign o_neg = o_ind ? (i_mode == 3'd1) : tg;
  assign o_col_valid = o_ind ? i_mode[1] : tg;
  assign o_col_sig = (o_ind && i_mode != 3'd3) ? sig : ~sig;
  assign o_ca_valid = o_ind ? 1'b1 : tg;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pend <= 1'b0;
      tg <= 1'b0;
      cnt <= 8'h00;
      sig <= 4'h0;
      o_ind <= 1'b0;
    end else begin
      tg <= ~tg;
      o_ind <= 1'b0;
      if (i_cd_tx) begin
        pend <= 1'b1;
        cnt <= i_dly;
        sig <= i_cd_sig;
      end else if (pend && cnt == 8'h00) begin
        pend <= 1'b0;
        o_ind <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // common_packet_channel_net_model

// File: packet_channel_access_sequencer_tb.sv
module packet_channel_access_sequencer_tb
  import common_packet_channel_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_rst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_access_request = 0, i_message_end = 0;
  logic i_power_control_valid = 0, i_indicator_valid, i_ack_positive;
  logic i_ack_negative, i_collision_valid, i_channel_assignment_valid;
  logic [7:0] i_awaddr = 0, i_araddr = 0, dly = 8'h03, pw [4], mp;
  logic [31:0] i_wdata = 0, o_rdata, rd;
  logic [3:0] i_wstrb = 4'hF, i_collision_sig, o_access_preamble_sig;
  logic [1:0] i_requested_rate = 0, i_rate_status = 2'b11, rsp;
  logic [1:0] i_power_control_command = 0, o_bresp, o_rresp;
  logic [2:0] mode = 0, o_access_frame;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy, won;
  logic o_access_success, o_access_failure, o_access_preamble_tx;
  logic o_collision_detect_preamble_tx, o_message_preamble_tx;
  logic o_message_start, o_sub_frame_odd;
  logic [3:0] o_collision_detect_preamble_sig;
  logic signed [7:0] o_tx_offset;
  logic [7:0] o_preamble_power, o_message_power;
  int naps, miscompares = 0, total_checks = 0, cyc = 0;
  wire logic [3:0] i_channel_assignment = 4'd3;
  wire logic [15:0] i_channel_status_broadcast = 16'h0008;
  always #12.5 i_mclk = ~i_mclk;
  packet_channel_access_sequencer dut (.*);
  common_packet_channel_net_model net (.i_mclk, .i_rst,
    .i_cd_tx(o_collision_detect_preamble_tx),
    .i_cd_sig(o_collision_detect_preamble_sig), .i_mode(mode), .i_dly(dly),
    .o_ind(i_indicator_valid), .o_pos(i_ack_positive),
    .o_neg(i_ack_negative), .o_col_valid(i_collision_valid),
    .o_col_sig(i_collision_sig), .o_ca_valid(i_channel_assignment_valid));
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a; i_wdata <= d;
    i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    do @(posedge i_mclk); while (!(o_awready && o_wready));
    i_awvalid <= 0; i_wvalid <= 0;
    do @(posedge i_mclk); while (!o_bvalid);
    rsp = o_bresp; i_bready <= 0;
  endtask
  task rdr(input logic [7:0] a);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    do @(posedge i_mclk); while (!o_arready);
    i_arvalid <= 0;
    do @(posedge i_mclk); while (!o_rvalid);
    rd = o_rdata; rsp = o_rresp; i_rready <= 0;
  endtask
  task run(input logic [2:0] m, input logic [1:0] r, input bit dr);
    mode <= m; i_requested_rate <= r; i_access_request <= 1;
    naps = 0;
    @(posedge i_mclk);
    i_access_request <= 0;
    if (dr) i_rate_status <= 2'b00;
    do begin
      @(posedge i_mclk);
      if (o_access_preamble_tx && naps < 4) pw[naps++] = o_preamble_power;
      if (o_message_preamble_tx) mp = o_message_power;
    end while (!(o_access_success || o_access_failure));
    won = o_access_success; i_rate_status <= 2'b11;
    @(posedge i_mclk);
  endtask
  task t_regs;
    rdr(REG_INIT_POWER); chk("init power", 32'h0000_0010, rd);
    wr(REG_RETRY_LIMIT, 32'h0000_0001); rdr(REG_RETRY_LIMIT);
    chk("retry limit", 32'h0000_0001, rd);
    wr(REG_NEG_TIME, 32'h0000_FFFF); wr(8'h40, 32'h0000_0001);
    chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rdr(8'h40); chk("unmapped rd", 32'h0000_0000, rd);
  endtask
  task t_rate;
    i_rate_status <= 2'b01; run(0, 2'b10, 0);
    chk("rate refused aps", 0, naps); chk("rate won", 0, won);
  endtask
  task t_drop;
    run(0, 2'b01, 1); chk("drop aps", 0, naps);
  endtask
  task t_retry;
    dly <= 8'h28; run(0, 2'b00, 0);
    chk("retry aps", 2, naps); chk("retry won", 0, won);
    chk("first power", 8'h10, pw[0]);
    chk("normal ramp", 8'h11, pw[1]);
  endtask
  task t_neg;
    dly <= 8'h03; run(1, 2'b00, 0);
    chk("neg aps", 1, naps); chk("neg won", 0, won);
    run(0, 2'b00, 0); chk("reload power", 8'h10, pw[0]);
    chk("reload retry", 2, naps);
    chk("alt ramp", 8'h12, pw[1]);
  endtask
  task t_clash;
    run(3, 2'b00, 0); chk("clash won", 0, won);
  endtask
  task automatic t_success;
    logic [7:0] st [4] = '{8'hFE, 8'hFF, 8'h01, 8'h02};
    logic [7:0] prev;
    run(2, 2'b00, 0); chk("won", 1, won);
    chk("msg power", 8'(pw[0] + 8'h03), mp);
    for (int c = 0; c < 4; c++) begin
      prev = o_message_power;
      i_power_control_command <= 2'(c); i_power_control_valid <= 1;
      @(posedge i_mclk);
      i_power_control_valid <= 0;
      repeat (2) @(posedge i_mclk);
      chk("tpc power", 8'(prev + st[c]), o_message_power);
    end
    i_message_end <= 1; @(posedge i_mclk);
    i_message_end <= 0; repeat (2) @(posedge i_mclk);
    chk("busy after end", 0, o_busy);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling: every preamble at worst frame wait
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 0;
    @(posedge i_mclk);
    t_regs; t_rate; t_drop; t_retry; t_neg; t_clash; t_success;
    report_and_stop;
  end
endmodule // packet_channel_access_sequencer_tb
